// File: itmr_params.svh
// register offsets, field positions, reset values and timing counts of the interval timer
`ifndef ITMR_PARAMS_SVH
`define ITMR_PARAMS_SVH
`define ITMR_ADDR_W 4
`define ITMR_OFS_SUPPLY 4'h0
`define ITMR_OFS_GATE 4'h1
`define ITMR_OFS_IRQF 4'h2
`define ITMR_OFS_IRQM 4'h3
`define ITMR_OFS_CTRL 4'h4
`define ITMR_OFS_STAT 4'h5
`define ITMR_OFS_SMASK 4'h6
`define ITMR_OFS_CNT 4'h7
`define ITMR_BIT_CLKEN 7
`define ITMR_BIT_CKSEL 4
`define ITMR_BIT_LPC 7
`define ITMR_BIT_IRQ 2
`define ITMR_BIT_RUN 15
`define ITMR_CMP_W 12
`define ITMR_RST_SUPPLY 8'h00
`define ITMR_RST_GATE 8'h00
`define ITMR_RST_IRQF 8'h00
`define ITMR_RST_IRQM 8'h04
`define ITMR_RST_CTRL 16'h0000
`define ITMR_RST_SMASK 8'h00
`define ITMR_ZERO8 8'h00
`define ITMR_ZERO16 16'h0000
`define ITMR_CNT_ONE 12'h001
`define ITMR_CNT_ZERO 12'h000
`endif

// File: itmr_pkg.sv
// types shared by the interval timer files
package itmr_pkg;
  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_RUN = 2'b01
  } cnt_state_t;
endpackage

// File: itmr_tick_if.sv
// carrier between the count-clock edge detector and the timer core
`timescale 1ns/100ps
`default_nettype none
interface itmr_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire

// File: itmr_tick_sync.sv
// synchronises the two slow count clocks, selects one and emits a rising-edge tick
`timescale 1ns/100ps
`default_nettype none
`include "itmr_params.svh"
module itmr_tick_sync (
  input wire logic clk_i,          // system clock
  input wire logic rst_n_i,        // synchronous reset, active low
  input wire logic sub_clk_i,      // subsystem clock pin
  input wire logic losc_clk_i,     // low-speed oscillator pin
  input wire logic sel_losc_i,     // 1 selects low-speed oscillator
  input wire logic gate_i,         // clock supply enabled
  itmr_tick_if.src tk              // tick out
);
  logic [1:0] sub_s_r;
  logic [1:0] losc_s_r;
  logic prev_r;
  logic sel_w;

  // two-stage synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sub_s_r <= 2'h0;
      losc_s_r <= 2'h0;
    end else begin
      sub_s_r <= {sub_s_r[0], sub_clk_i};
      losc_s_r <= {losc_s_r[0], losc_clk_i};
    end
  end

  assign sel_w = sel_losc_i ? losc_s_r[1] : sub_s_r[1]; // RQ2

  // edge detector; a switch of source may give one spurious tick, software sets it while stopped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_r <= 1'b0;
      tk.tick <= 1'b0;
    end else begin
      prev_r <= sel_w;
      tk.tick <= gate_i & sel_w & ~prev_r; // RQ1
    end
  end
endmodule
`default_nettype wire

// File: itmr_top.sv
// 12-bit interval timer with its clock gate, clock select and interrupt registers
//
// Behaviour
// RQ1: gate bit 7 enables timer input clock
// RQ2: supply-mode bit 4 picks low-speed oscillator
// RQ3: supply-mode bit 7 limits standby subclock supply
// RQ4: run bit 15 counts; clearing stops, zeroes
// RQ5: interrupt every compare plus one ticks
// RQ6: request flag bit 2 set; cleared writing zero
// RQ7: mask bit 2 gates servicing, not flag
// RQ8: counter wraps at match; bits 14-12 zero
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "itmr_params.svh"
module itmr_top (
  input wire logic clk_i,            // 200 MHz system clock
  input wire logic rst_n_i,          // synchronous reset, active low
  input wire logic [3:0] addr_i,     // register index
  input wire logic [15:0] wdata_i,   // write data
  input wire logic wr_i,             // write strobe
  input wire logic rd_i,             // read strobe
  output logic [15:0] rdata_o,       // read data, cycle after strobe
  input wire logic sub_clk_i,        // subsystem clock pin
  input wire logic losc_clk_i,       // low-speed oscillator pin
  input wire logic standby_i,        // STOP, or HALT on subclock
  output logic periph_sub_en_o,      // subclock to other peripherals
  output logic interval_timer_interrupt_o, // timer interrupt request pulse
  output logic irq_o                 // level interrupt
);
  // register map by index:
  //   0 supply mode: bit 4 count clock source, bit 7 standby subclock gate
  //   1 clock gate: bit 7 feeds the timer its input clock
  //   2 request flags: bit 2 set on match, software writes zero to clear
  //   3 request masks: bit 2 blocks servicing only, resets to masked
  //   4 control: bit 15 run, bits 11-0 compare value, bits 14-12 read zero
  //   5 sticky status: bit 2 set on match, write one to clear
  //   6 status mask: a one keeps that status bit off the level interrupt
  //   7 live count, read only
  //   other indices ignore writes and read zero
  logic [7:0] subclock_supply_mode_r;
  logic [7:0] peripheral_clock_gate_two_r;
  logic [7:0] irq_request_flags_upper1_r;
  logic [7:0] irq_mask_flags_upper1_r;
  logic [15:0] interval_timer_control_r;
  logic [11:0] count_r;
  logic [11:0] count_nxt;
  logic [7:0] stat_r;
  logic [7:0] smask_r;
  logic match_w;
  logic run_w;
  logic [15:0] rd_nxt;
  itmr_pkg::cnt_state_t st_r;
  itmr_tick_if tk ();
  logic clk_en_w;
  logic cksel_w;
  logic lpc_w;
  logic flag_w;
  logic mask_w;
  logic stat_pend_w;
  logic [11:0] cmp_w;
  logic at_cmp_w;
  logic wr_supply_w;
  logic wr_gate_w;
  logic wr_flag_w;
  logic wr_mask_w;
  logic wr_ctrl_w;
  logic wr_stat_w;
  logic wr_smask_w;

  // write decode shared by every register
  function automatic logic wr_at(input logic [3:0] a, input logic [3:0] ofs, input logic w);
    wr_at = w && (a == ofs);
  endfunction

  // the byte-wide registers sit in the low half of the read word
  function automatic logic [15:0] ext8(input logic [7:0] v);
    ext8 = {`ITMR_ZERO8, v};
  endfunction

  itmr_tick_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sub_clk_i(sub_clk_i),
    .losc_clk_i(losc_clk_i),
    .sel_losc_i(cksel_w),
    .gate_i(clk_en_w),
    .tk(tk)
  );

  // one strobe per register, so each process below owns one concern
  assign wr_supply_w = wr_at(addr_i, `ITMR_OFS_SUPPLY, wr_i);
  assign wr_gate_w = wr_at(addr_i, `ITMR_OFS_GATE, wr_i);
  assign wr_flag_w = wr_at(addr_i, `ITMR_OFS_IRQF, wr_i);
  assign wr_mask_w = wr_at(addr_i, `ITMR_OFS_IRQM, wr_i);
  assign wr_ctrl_w = wr_at(addr_i, `ITMR_OFS_CTRL, wr_i);
  assign wr_stat_w = wr_at(addr_i, `ITMR_OFS_STAT, wr_i);
  assign wr_smask_w = wr_at(addr_i, `ITMR_OFS_SMASK, wr_i);

  // named fields, so the logic below reads like the register map
  assign clk_en_w = peripheral_clock_gate_two_r[`ITMR_BIT_CLKEN]; // RQ1
  assign cksel_w = subclock_supply_mode_r[`ITMR_BIT_CKSEL]; // RQ2
  assign lpc_w = subclock_supply_mode_r[`ITMR_BIT_LPC]; // RQ3
  assign flag_w = irq_request_flags_upper1_r[`ITMR_BIT_IRQ]; // RQ6
  assign mask_w = irq_mask_flags_upper1_r[`ITMR_BIT_IRQ]; // RQ7
  assign stat_pend_w = |(stat_r & ~smask_r);
  assign cmp_w = interval_timer_control_r[`ITMR_CMP_W-1:0]; // RQ5

  assign run_w = interval_timer_control_r[`ITMR_BIT_RUN];
  assign at_cmp_w = (count_r == cmp_w);
  // compare value zero is prohibited; with zero the timer fires every tick
  // rather than never, which keeps a misprogrammed timer visible
  assign match_w = tk.tick && (st_r == itmr_pkg::CNT_RUN) && at_cmp_w; // RQ5

  // supply-mode register: count clock source and standby policy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      subclock_supply_mode_r <= `ITMR_RST_SUPPLY;
    end else if (wr_supply_w) begin
      subclock_supply_mode_r <= wdata_i[7:0]; // RQ2
    end
  end

  // clock gate register; with the gate shut no tick reaches the counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      peripheral_clock_gate_two_r <= `ITMR_RST_GATE;
    end else if (wr_gate_w) begin
      peripheral_clock_gate_two_r <= wdata_i[7:0]; // RQ1
    end
  end

  // request mask; resets masked so the flag is not serviced before setup; sticky status still reaches irq_o
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_mask_flags_upper1_r <= `ITMR_RST_IRQM;
    end else if (wr_mask_w) begin
      irq_mask_flags_upper1_r <= wdata_i[7:0]; // RQ7
    end
  end

  // status mask for the sticky status register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      smask_r <= `ITMR_RST_SMASK;
    end else if (wr_smask_w) begin
      smask_r <= wdata_i[7:0];
    end
  end

  // control register; bits 14-12 are not stored so they read zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      interval_timer_control_r <= `ITMR_RST_CTRL;
    end else if (wr_ctrl_w) begin
      interval_timer_control_r <= {wdata_i[`ITMR_BIT_RUN], 3'h0,
        wdata_i[`ITMR_CMP_W-1:0]}; // RQ8
    end
  end

  // run state follows the run bit; leaving run clears the count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= itmr_pkg::CNT_IDLE;
    end else begin
      st_r <= run_w ? itmr_pkg::CNT_RUN : itmr_pkg::CNT_IDLE; // RQ4
    end
  end

  always_comb begin
    count_nxt = count_r;
    unique case (st_r)
      itmr_pkg::CNT_IDLE: count_nxt = `ITMR_CNT_ZERO; // RQ4
      itmr_pkg::CNT_RUN: begin
        if (!run_w) begin
          count_nxt = `ITMR_CNT_ZERO; // RQ4
        end else if (match_w) begin
          count_nxt = `ITMR_CNT_ZERO; // RQ8
        end else if (tk.tick) begin
          count_nxt = count_r + `ITMR_CNT_ONE;
        end
      end
      default: count_nxt = `ITMR_CNT_ZERO;
    endcase
  end

  // count register; only the comb process above decides its next value
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_r <= `ITMR_CNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  // request flag: hardware set wins over a software clear in the same cycle
  // so a match that lands on the clear is never lost
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_request_flags_upper1_r <= `ITMR_RST_IRQF;
    end else begin
      if (wr_flag_w) begin
        irq_request_flags_upper1_r <= wdata_i[7:0]; // RQ6
      end
      if (match_w) begin
        irq_request_flags_upper1_r[`ITMR_BIT_IRQ] <= 1'b1; // RQ6
      end
    end
  end

  // sticky status, write one to clear; set beats clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stat_r <= `ITMR_ZERO8;
    end else begin
      if (wr_stat_w) begin
        stat_r <= stat_r & ~wdata_i[7:0];
      end
      if (match_w) begin
        stat_r[`ITMR_BIT_IRQ] <= 1'b1;
      end
    end
  end

  // one-cycle request pulse per compare match
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      interval_timer_interrupt_o <= 1'b0;
    end else begin
      interval_timer_interrupt_o <= match_w; // RQ5
    end
  end

  // level interrupt; the mask only gates servicing, never the flag
  // match is folded in so the unmasked level rises with the pulse, not a cycle later
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ((flag_w | match_w) & ~mask_w) | stat_pend_w; // RQ7
    end
  end

  // in standby the lowpower bit withholds subclock from all but timer-class blocks
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      periph_sub_en_o <= 1'b1;
    end else begin
      periph_sub_en_o <= !(standby_i && lpc_w); // RQ3
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = `ITMR_ZERO16;
    unique case (addr_i)
      `ITMR_OFS_SUPPLY: rd_nxt = ext8(subclock_supply_mode_r);
      `ITMR_OFS_GATE: rd_nxt = ext8(peripheral_clock_gate_two_r);
      `ITMR_OFS_IRQF: rd_nxt = ext8(irq_request_flags_upper1_r);
      `ITMR_OFS_IRQM: rd_nxt = ext8(irq_mask_flags_upper1_r);
      `ITMR_OFS_CTRL: rd_nxt = interval_timer_control_r; // RQ8
      `ITMR_OFS_STAT: rd_nxt = ext8(stat_r);
      `ITMR_OFS_SMASK: rd_nxt = ext8(smask_r);
      `ITMR_OFS_CNT: rd_nxt = {4'h0, count_r};
      default: rd_nxt = `ITMR_ZERO16;
    endcase
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  // so a stale value can never be mistaken for a fresh read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= `ITMR_ZERO16;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end else begin
      rdata_o <= `ITMR_ZERO16;
    end
  end
endmodule
`default_nettype wire

// File: itmr_chk.sv
// assertion checker watching the interval timer ports
`timescale 1ns/100ps
`default_nettype none
module itmr_chk (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic [3:0] addr_i, // index
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [15:0] rdata_o, // read data
  input wire logic standby_i, // standby level
  input wire logic periph_sub_en_o, // subclock supply
  input wire logic interval_timer_interrupt_o, // match pulse
  input wire logic irq_o // level interrupt
);
  logic [15:0] ctl_r;
  logic lpc_r;
  logic gate_r;
  logic msk_r;
  // shadow of what software wrote, so outputs can be tied to their cause
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_r <= 16'h0000;
      lpc_r <= 1'b0;
      gate_r <= 1'b0;
      msk_r <= 1'b1;
    end else if (wr_i) begin
      if (addr_i == 4'h4) ctl_r <= wdata_i & 16'h8FFF;
      if (addr_i == 4'h0) lpc_r <= wdata_i[7];
      if (addr_i == 4'h1) gate_r <= wdata_i[7];
      if (addr_i == 4'h3) msk_r <= wdata_i[2];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_ctl;
    rd_i && addr_i == 4'h4;
  endsequence
  ctl_read_a: assert property (rd_ctl |=> rdata_o == $past(ctl_r))
    else $error("control read mismatch");
  idle_read_a: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero");
  pulse_width_a: assert property (interval_timer_interrupt_o |=> !interval_timer_interrupt_o)
    else $error("pulse longer than one cycle");
  stop_quiet_a: assert property (!ctl_r[15] [*3] |-> !interval_timer_interrupt_o)
    else $error("pulse while stopped");
  gate_quiet_a: assert property (!gate_r [*8] |-> !interval_timer_interrupt_o)
    else $error("pulse with clock gated");
  lpc_stop_a: assert property ((standby_i && lpc_r) [*3] |-> !periph_sub_en_o)
    else $error("subclock not withheld");
  lpc_pass_a: assert property ((!standby_i || !lpc_r) [*3] |-> periph_sub_en_o)
    else $error("subclock withheld");
  mask_irq_a: assert property (interval_timer_interrupt_o && !msk_r |-> ##[0:2] irq_o)
    else $error("unmasked request not raised");
endmodule
`default_nettype wire

// File: itmr_top_bench.sv
// self-checking bench for the interval timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %0h exp %0h", $time, g, e); end end
module itmr_top_bench;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic sub_clk_i = 1'b0, losc_clk_i = 1'b0, standby_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic periph_sub_en_o, interval_timer_interrupt_o, irq_o;
  logic [3:0] div = 4'h0;
  int num_errors = 0, samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  // count clocks locked to clk so pulse spacing is exact: 8 and 16 cycles
  always @(posedge clk_i) begin
    div <= div + 4'h1;
    if (div[1:0] == 2'h3) sub_clk_i <= ~sub_clk_i;
    if (div[2:0] == 3'h7) losc_clk_i <= ~losc_clk_i;
  end
  itmr_top dut_u (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sub_clk_i,
    .losc_clk_i, .standby_i, .periph_sub_en_o, .interval_timer_interrupt_o, .irq_o);
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cycles to the next pulse; bounded so a dead timer ends the run
  task automatic wp(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 400) begin
        num_errors++;
        finish_test();
      end
    end while (interval_timer_interrupt_o !== 1'b1);
  endtask
  task automatic t_regs();
    logic [15:0] d;
    rd(4'h3, d);
    `CHK(d, 16'h0004)
    wr(4'h4, 16'h7FFF);
    rd(4'h4, d);
    `CHK(d, 16'h0FFF)
    wr(4'hC, 16'hFFFF);
    rd(4'hC, d);
    `CHK(d, 16'h0000)
    `CHK(periph_sub_en_o, 1'b1)
    $display("test regs done");
  endtask
  // second interval is free of start-up skew
  task automatic t_period(input logic [15:0] sup, input logic [15:0] ctl, input int exp);
    int n;
    logic [15:0] d;
    wr(4'h0, sup);
    wr(4'h1, 16'h0080);
    wr(4'h4, ctl);
    wp(n);
    wp(n);
    `CHK(n, exp)
    wr(4'h4, 16'h0000);
    rd(4'h7, d);
    `CHK(d, 16'h0000)
    $display("test period done");
  endtask
  task automatic t_gate();
    int k;
    k = 0;
    wr(4'h1, 16'h0000);
    wr(4'h4, 16'h8001);
    repeat (100) begin
      @(posedge clk_i);
      if (interval_timer_interrupt_o === 1'b1) k++;
    end
    `CHK(k, 0)
    $display("test gate done");
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq_o, e)
  endtask
  task automatic t_irq();
    int n;
    logic [15:0] d;
    wr(4'h6, 16'h0004);
    wr(4'h1, 16'h0080);
    wp(n);
    wr(4'h4, 16'h0000);
    rd(4'h2, d);
    `CHK(d[2], 1'b1)
    chk_irq(1'b0);
    wr(4'h3, 16'h0000);
    chk_irq(1'b1);
    wr(4'h2, 16'h0000);
    chk_irq(1'b0);
    wr(4'h6, 16'h0000);
    chk_irq(1'b1);
    wr(4'h5, 16'h0004);
    chk_irq(1'b0);
    $display("test irq done");
  endtask
  task automatic t_standby();
    standby_i <= 1'b1;
    wr(4'h0, 16'h0080);
    repeat (3) @(posedge clk_i);
    `CHK(periph_sub_en_o, 1'b0)
    wr(4'h0, 16'h0000);
    repeat (3) @(posedge clk_i);
    `CHK(periph_sub_en_o, 1'b1)
    standby_i <= 1'b0;
    $display("test standby done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_period(16'h0000, 16'h8003, 32);
    t_period(16'h0010, 16'h8001, 32);
    t_period(16'h0000, 16'h800A, 88);
    t_gate();
    t_irq();
    t_standby();
    finish_test();
  end
endmodule
bind itmr_top itmr_chk chk_u (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .standby_i, .periph_sub_en_o, .interval_timer_interrupt_o, .irq_o);
`default_nettype wire
